// *** aoc_top.sv ***
// Purpose: Alarm contact output controller: frame check, output register, contacts.
// Assumes: All inputs synchronous to i_clk_sys; contact outputs high = closed.
// Notes:   Contacts stay open from reset until the first verified transfer.
`timescale 1ns/1ps
module aoc_top #(
    parameter int unsigned FRAME_W     = aoc_pkg::FRAME_BITS,
    parameter int unsigned TICK_CYC    = aoc_pkg::TICK_CYCLES,
    parameter int unsigned WIN_TICKS   = aoc_pkg::OK_WINDOW_TICKS,
    parameter int unsigned FLASH_TICKS = aoc_pkg::FLASH_TICKS
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // Sensor bus frame input
    input  wire logic        i_ser_frame,
    input  wire logic        i_ser_bit_en,
    input  wire logic        i_ser_data,
    // User switches
    input  wire logic        i_polarity_close_on_active,
    input  wire logic        i_enable,
    input  wire logic        i_power_ok,
    input  wire logic [3:0]  i_sel_first,
    input  wire logic [3:0]  i_sel_second,
    input  wire logic [3:0]  i_sel_third,
    input  wire logic [3:0]  i_sel_fourth,
    // Returned verified transfer pulse
    output logic             o_load_return,
    // Contacts
    output logic [3:0]       o_contact_direct,
    output logic             o_contact_latch_relay_one,
    output logic             o_contact_latch_relay_two,
    output logic             o_contact_ok,
    // Indicators
    output logic [5:0]       o_led_relay,
    output logic             o_led_ok,
    output logic             o_led_transfer,
    output logic [15:0]      o_out_reg
);
    localparam int unsigned DATA_W  = aoc_pkg::DATA_BITS;
    localparam int unsigned FLASH_W = $clog2(FLASH_TICKS + 1);
    localparam logic [FLASH_W-1:0] FLASH_LOAD = FLASH_W'(FLASH_TICKS);

    // Picks one output register bit by its index
    function automatic logic pick_bit(input logic [DATA_W-1:0] word, input logic [3:0] idx);
        pick_bit = word[idx];
    endfunction

    aoc_xfer_if #(.DATA_W(DATA_W)) xfer ();

    aoc_frame_rx #(
        .FRAME_W (FRAME_W)
    ) u_rx (
        .i_clk_sys    (i_clk_sys),
        .i_rst        (i_rst),
        .i_ser_frame  (i_ser_frame),
        .i_ser_bit_en (i_ser_bit_en),
        .i_ser_data   (i_ser_data),
        .xfer         (xfer.rx)
    );

    logic recent;

    aoc_valid_timer #(
        .TICK_CYC  (TICK_CYC),
        .WIN_TICKS (WIN_TICKS)
    ) u_timer (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .xfer      (xfer.timer),
        .o_recent  (recent)
    );

    // Output register and first-load flag
    logic [DATA_W-1:0] out_reg;
    logic              loaded;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            out_reg <= aoc_pkg::OUT_REG_RESET;
            loaded  <= 1'b0;
        end else if (xfer.load) begin
            out_reg <= xfer.data;
            loaded  <= 1'b1;
        end
    end

    // Selection and polarity
    logic [3:0] sel_idx [4];
    assign sel_idx[0] = i_sel_first;
    assign sel_idx[1] = i_sel_second;
    assign sel_idx[2] = i_sel_third;
    assign sel_idx[3] = i_sel_fourth;

    logic [3:0] direct_cmd;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_direct
            wire sel_bit = pick_bit(out_reg, sel_idx[g]);
            assign direct_cmd[g] = loaded &
                (i_polarity_close_on_active ? sel_bit : ~sel_bit);
        end
    endgenerate

    // Set/reset latches; reset wins when both are asserted
    logic latch_one;
    logic latch_two;
    logic next_latch_one;
    logic next_latch_two;

    assign next_latch_one = direct_cmd[1] ? 1'b0 : (direct_cmd[0] ? 1'b1 : latch_one);
    assign next_latch_two = direct_cmd[3] ? 1'b0 : (direct_cmd[2] ? 1'b1 : latch_two);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            latch_one <= 1'b0;
            latch_two <= 1'b0;
        end else begin
            latch_one <= next_latch_one;
            latch_two <= next_latch_two;
        end
    end

    // Commanded state of all six relays, before the enable
    wire [5:0] relay_cmd = {latch_two, latch_one, direct_cmd};

    // Validity: no polarity term
    wire ok_now = recent & i_enable & i_power_ok;

    // Transfer indicator stretch
    logic [FLASH_W-1:0] flash_cnt;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            flash_cnt <= '0;
        end else if (xfer.load) begin
            flash_cnt <= FLASH_LOAD;
        end else if (xfer.tick && flash_cnt != '0) begin
            flash_cnt <= flash_cnt - FLASH_W'(1);
        end
    end

    // Registered outputs
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_contact_direct          <= '0;
            o_contact_latch_relay_one <= 1'b0;
            o_contact_latch_relay_two <= 1'b0;
            o_contact_ok              <= 1'b0;
            o_led_relay               <= '0;
            o_led_ok                  <= 1'b0;
            o_led_transfer            <= 1'b0;
            o_load_return             <= 1'b0;
            o_out_reg                 <= aoc_pkg::OUT_REG_RESET;
        end else begin
            o_contact_direct          <= relay_cmd[3:0] & {4{i_enable & loaded}};
            o_contact_latch_relay_one <= relay_cmd[aoc_pkg::RELAY_LATCH_ONE] & i_enable & loaded;
            o_contact_latch_relay_two <= relay_cmd[aoc_pkg::RELAY_LATCH_TWO] & i_enable & loaded;
            o_contact_ok              <= ok_now;
            o_led_relay               <= relay_cmd;
            o_led_ok                  <= ok_now;
            o_led_transfer            <= xfer.load | (flash_cnt != '0);
            o_load_return             <= xfer.load;
            o_out_reg                 <= out_reg;
        end
    end
endmodule // aoc_top

// *** aoc_pkg.sv ***
// Purpose: Shared constants for the alarm contact output controller.
// Assumes: 100 MHz system clock.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
package aoc_pkg;

    // System clock
    localparam int unsigned CLK_PERIOD_NS = 10;

    // Frame layout: true copy first, inverted copy second, most significant bit first
    localparam int unsigned DATA_BITS  = 16;
    localparam int unsigned FRAME_BITS = 2 * DATA_BITS;

    // Timebase: one tick per millisecond
    localparam int unsigned TICK_MS     = 1;
    localparam int unsigned TICK_CYCLES = (TICK_MS * 1000000) / CLK_PERIOD_NS;

    // Validity window after a verified transfer
    localparam int unsigned OK_WINDOW_S     = 10;
    localparam int unsigned OK_WINDOW_TICKS = (OK_WINDOW_S * 1000) / TICK_MS;

    // Visible length of the transfer indicator flash
    localparam int unsigned FLASH_MS    = 50;
    localparam int unsigned FLASH_TICKS = FLASH_MS / TICK_MS;

    // Reset values
    localparam logic [DATA_BITS-1:0] OUT_REG_RESET = 16'h0000;

    // Relay indices within the six-relay indicator vector
    localparam int unsigned RELAY_LATCH_ONE = 4;
    localparam int unsigned RELAY_LATCH_TWO = 5;

endpackage : aoc_pkg

// *** aoc_xfer_if.sv ***
// Purpose: Carries a verified transfer from the frame receiver to its users.
// Assumes: One clock domain.
// Notes:   load is a one-cycle pulse; data is stable while load is high.
`timescale 1ns/1ps
interface aoc_xfer_if #(
    parameter int unsigned DATA_W = aoc_pkg::DATA_BITS
);
    logic              load;
    logic [DATA_W-1:0] data;
    logic              tick;

    modport rx    (output load, output data);
    modport sink  (input  load, input  data, input tick);
    modport timer (input  load, output tick);
endinterface : aoc_xfer_if

// *** aoc_frame_rx.sv ***
// Purpose: Collects one serial frame and verifies length and complement.
// Assumes: i_ser_bit_en marks a valid bit while i_ser_frame is high.
// Notes:   The check runs on the cycle after i_ser_frame falls.
`timescale 1ns/1ps
module aoc_frame_rx #(
    parameter int unsigned FRAME_W = aoc_pkg::FRAME_BITS
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_ser_frame,
    input  wire logic i_ser_bit_en,
    input  wire logic i_ser_data,
    aoc_xfer_if.rx    xfer
);
    localparam int unsigned HALF_W = FRAME_W / 2;
    localparam int unsigned CNT_W  = $clog2(FRAME_W + 2);
    localparam logic [CNT_W-1:0] CNT_MAX  = CNT_W'(FRAME_W + 1);
    localparam logic [CNT_W-1:0] CNT_GOOD = CNT_W'(FRAME_W);

    logic [FRAME_W-1:0] shreg;
    logic [CNT_W-1:0]   bit_cnt;
    logic               frame_q;
    logic               load;
    logic [HALF_W-1:0]  data;

    wire frame_end  = frame_q & ~i_ser_frame;
    wire take_bit   = i_ser_frame & i_ser_bit_en;
    wire len_ok     = (bit_cnt == CNT_GOOD);
    wire copy_ok    = (shreg[FRAME_W-1:HALF_W] == ~shreg[HALF_W-1:0]);
    wire frame_good = frame_end & len_ok & copy_ok;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            shreg   <= '0;
            bit_cnt <= '0;
            frame_q <= 1'b0;
        end else begin
            frame_q <= i_ser_frame;
            if (frame_end) begin
                bit_cnt <= '0;
            end else if (take_bit) begin
                shreg <= {shreg[FRAME_W-2:0], i_ser_data};
                if (bit_cnt != CNT_MAX) begin
                    bit_cnt <= bit_cnt + CNT_W'(1);
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            load <= 1'b0;
            data <= aoc_pkg::OUT_REG_RESET;
        end else begin
            load <= frame_good;
            if (frame_good) begin
                data <= shreg[FRAME_W-1:HALF_W];
            end
        end
    end

    assign xfer.load = load;
    assign xfer.data = data;
endmodule // aoc_frame_rx

// *** aoc_valid_timer.sv ***
// Purpose: Millisecond timebase and the recent-transfer window.
// Assumes: One clock; load is a one-cycle pulse.
// Notes:   The window restarts on every verified transfer.
`timescale 1ns/1ps
module aoc_valid_timer #(
    parameter int unsigned TICK_CYC  = aoc_pkg::TICK_CYCLES,
    parameter int unsigned WIN_TICKS = aoc_pkg::OK_WINDOW_TICKS
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    aoc_xfer_if.timer xfer,
    output logic      o_recent
);
    localparam int unsigned DIV_W = $clog2(TICK_CYC + 1);
    localparam int unsigned WIN_W = $clog2(WIN_TICKS + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYC - 1);
    localparam logic [WIN_W-1:0] WIN_LOAD = WIN_W'(WIN_TICKS);

    logic [DIV_W-1:0] div_cnt;
    logic [WIN_W-1:0] win_cnt;
    logic             tick;

    wire div_wrap = (div_cnt == DIV_LAST);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            div_cnt <= '0;
            tick    <= 1'b0;
        end else begin
            tick    <= div_wrap;
            div_cnt <= div_wrap ? '0 : div_cnt + DIV_W'(1);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            win_cnt <= '0;
        end else if (xfer.load) begin
            win_cnt <= WIN_LOAD;
        end else if (tick && win_cnt != '0) begin
            win_cnt <= win_cnt - WIN_W'(1);
        end
    end

    assign o_recent  = (win_cnt != '0);
    assign xfer.tick = tick;
endmodule // aoc_valid_timer

// *** aoc_top_monitor.sv ***
// Purpose: Port-level assertions for the alarm contact output controller.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound into every aoc_top instance.
`timescale 1ns/1ps
module aoc_top_monitor #(
    parameter int unsigned TICK_CYC  = 100000,
    parameter int unsigned WIN_TICKS = 10000
) (
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    input wire logic        i_ser_frame,
    input wire logic        i_enable,
    input wire logic        i_power_ok,
    input wire logic        o_load_return,
    input wire logic [3:0]  o_contact_direct,
    input wire logic        o_contact_latch_relay_one,
    input wire logic        o_contact_latch_relay_two,
    input wire logic        o_contact_ok,
    input wire logic        o_led_transfer,
    input wire logic [15:0] o_out_reg
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    logic        loaded;
    int unsigned since;
    wire         all_open = o_contact_direct == 4'h0 && !o_contact_latch_relay_one
                            && !o_contact_latch_relay_two && !o_contact_ok;
    // Cycles since the last returned load, saturating past the window
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            loaded <= 1'b0;
            since  <= 0;
        end else begin
            loaded <= loaded | o_load_return;
            since  <= o_load_return ? 0 : (since > (WIN_TICKS + 2) * TICK_CYC ? since : since + 1);
        end
    end
    ret_single_a: assert property (o_load_return |=> !o_load_return)
        else $error("load return too long");
    ret_frame_a: assert property (o_load_return |-> $past(i_ser_frame, 3) && !$past(i_ser_frame, 2))
        else $error("load return not tied to frame end");
    flash_load_a: assert property (o_load_return |-> o_led_transfer)
        else $error("no flash on load");
    flash_cause_a: assert property ($rose(o_led_transfer) |-> o_load_return)
        else $error("flash without load");
    reg_change_a: assert property ($changed(o_out_reg) |-> $past(o_load_return))
        else $error("output register changed without load");
    open_first_a: assert property (!(loaded || o_load_return) |-> all_open)
        else $error("contact closed before first load");
    enable_off_a: assert property (!i_enable [*3] |-> all_open)
        else $error("contact closed while disabled");
    ok_power_a: assert property (!i_power_ok [*3] |-> !o_contact_ok)
        else $error("ok closed without power");
    ok_expire_a: assert property (o_contact_ok |-> since <= (WIN_TICKS + 1) * TICK_CYC + 4)
        else $error("ok closed past window");
endmodule // aoc_top_monitor
bind aoc_top aoc_top_monitor #(.TICK_CYC(TICK_CYC), .WIN_TICKS(WIN_TICKS)) mon (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ser_frame(i_ser_frame), .i_enable(i_enable),
    .i_power_ok(i_power_ok), .o_load_return(o_load_return), .o_contact_direct(o_contact_direct),
    .o_contact_latch_relay_one(o_contact_latch_relay_one), .o_contact_latch_relay_two(o_contact_latch_relay_two),
    .o_contact_ok(o_contact_ok), .o_led_transfer(o_led_transfer), .o_out_reg(o_out_reg));

// *** aoc_console_model.sv ***
// Purpose: Console side of the sensor bus, sending doubled alarm frames.
// Assumes: Bits change on the falling clock edge.
// Notes:   Data line toggles in each gap cycle and when the frame ends.
`timescale 1ns/1ps
module aoc_console_model (
    input  wire logic i_clk,
    output logic      o_frame  = 1'b0,
    output logic      o_bit_en = 1'b0,
    output logic      o_data   = 1'b0
);
    // Sends n bits; flip >= 0 corrupts that frame position; gap slows the console
    task automatic send(input logic [15:0] d, input int n, input int flip, input int gap);
        logic [31:0] f;
        f = {d, ~d};
        if (flip >= 0) f[flip] = ~f[flip];
        @(negedge i_clk);
        o_frame = 1'b1;
        for (int k = 0; k < n; k++) begin
            @(negedge i_clk);
            o_bit_en = 1'b1;
            o_data   = f[31 - (k % 32)];
            repeat (gap) begin
                @(negedge i_clk);
                o_bit_en = 1'b0;
                o_data   = ~o_data;
            end
        end
        @(negedge i_clk);
        o_bit_en = 1'b0;
        o_frame  = 1'b0;
        o_data   = ~o_data;
    endtask
endmodule // aoc_console_model

// *** testbench.sv ***
// Purpose: Self-checking bench for the alarm contact output controller.
// Assumes: Short timebase parameters; console model drives the sensor bus.
// Notes:   Inputs change on the falling clock edge.
`timescale 1ns/1ps
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        frame, bit_en, ser, ret, c_l1, c_l2, c_ok, l_ok, l_tr;
    logic        pol = 1'b0, en = 1'b1, pwr = 1'b1, ld = 1'b0, m1 = 1'b0, m2 = 1'b0;
    logic [3:0]  sel [4] = '{4'h0, 4'h1, 4'h2, 4'h3};
    logic [3:0]  c_dir;
    logic [5:0]  l_rel;
    logic [15:0] oreg, r = 16'h0000;
    int          fail_count = 0, n_tests = 0, n_ret = 0, exp_ret = 0, cyc = 0;
    always #5 clk = ~clk;
    aoc_top #(.TICK_CYC(4), .WIN_TICKS(20), .FLASH_TICKS(3)) dut (
        .i_clk_sys(clk), .i_rst(rst), .i_ser_frame(frame), .i_ser_bit_en(bit_en), .i_ser_data(ser),
        .i_polarity_close_on_active(pol), .i_enable(en), .i_power_ok(pwr), .i_sel_first(sel[0]),
        .i_sel_second(sel[1]), .i_sel_third(sel[2]), .i_sel_fourth(sel[3]), .o_load_return(ret),
        .o_contact_direct(c_dir), .o_contact_latch_relay_one(c_l1), .o_contact_latch_relay_two(c_l2),
        .o_contact_ok(c_ok), .o_led_relay(l_rel), .o_led_ok(l_ok), .o_led_transfer(l_tr), .o_out_reg(oreg));
    aoc_console_model con (.i_clk(clk), .o_frame(frame), .o_bit_en(bit_en), .o_data(ser));
    function automatic logic [3:0] sig4();
        for (int i = 0; i < 4; i++) sig4[i] = r[sel[i]] ^ ~pol;
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask
    // Latch model: reset input wins over set
    task automatic upd();
        logic [3:0] s;
        s = sig4();
        if (ld) m1 = s[1] ? 1'b0 : (s[0] ? 1'b1 : m1);
        if (ld) m2 = s[3] ? 1'b0 : (s[2] ? 1'b1 : m2);
    endtask
    task automatic chk_all(input string nm, input logic ok_e);
        logic [3:0] s;
        s = sig4();
        chk("out_reg", r, oreg);
        chk("direct", {12'h000, s & {4{en & ld}}}, {12'h000, c_dir});
        chk("relay_leds", {10'h000, m2, m1, s & {4{ld}}}, {10'h000, l_rel});
        chk("latches", {14'h0000, m2 & en, m1 & en}, {14'h0000, c_l2, c_l1});
        chk("ok", {14'h0000, ok_e, ok_e}, {14'h0000, c_ok, l_ok});
        chk("returns", exp_ret[15:0], n_ret[15:0]);
        $display("test %s done", nm);
    endtask
    task automatic xfer(input logic [15:0] d, input int n, input int flip);
        logic good;
        good = n == 32 && flip < 0;
        upd();
        con.send(d, n, flip, $urandom_range(1, 0));
        repeat (6) @(negedge clk);
        chk("flash", {15'h0000, good}, {15'h0000, l_tr});
        if (good) begin
            r = d;
            ld = 1'b1;
            exp_ret++;
            upd();
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Sampled off the launching edge so a one-cycle return pulse is counted exactly once
    always @(negedge clk) begin
        cyc++;
        if (ret === 1'b1) n_ret++;
        if (cyc == 6000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        void'($urandom(63348));
        repeat (10) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk_all("after_reset", 1'b0);
        pol = 1'b1;
        xfer(16'hA5C3, 31, -1);
        xfer(16'hA5C3, 33, -1);
        xfer(16'hA5C3, 32, 3);
        xfer(16'hA5C3, 32, 20);
        chk_all("bad_frames", 1'b0);
        for (int k = 0; k < 12; k++) begin
            foreach (sel[i]) sel[i] = 4'($urandom_range(15, 0));
            en = k < 2 ? 1'b1 : 1'($urandom_range(1, 0));
            xfer(k == 0 ? 16'hFFFF : (k == 1 ? 16'h0000 : 16'($urandom())), 32, -1);
            chk_all("random_load", en);
        end
        en = 1'b1;
        xfer(16'h8001, 32, -1);
        pwr = 1'b0;
        repeat (4) @(negedge clk);
        chk_all("power_off", 1'b0);
        pwr = 1'b1;
        repeat (4) @(negedge clk);
        chk_all("power_back", 1'b1);
        repeat (100) @(negedge clk);
        chk_all("window_expired", 1'b0);
        chk("flash_off", 16'h0000, {15'h0000, l_tr});
        xfer(16'h1234, 32, 7);
        chk_all("late_bad_frame", 1'b0);
        pol = 1'b0;
        xfer(16'h00F0, 32, -1);
        chk_all("open_on_active", 1'b1);
        results();
    end
endmodule // testbench
